// ### epm_pkg.sv
// Shared constants for the dual-port MII/RMII pin block
package epm_pkg;
    // Ports and lane widths
    localparam int        NUM_PORTS     = 2;
    localparam int        MII_WIDTH     = 4;
    localparam int        RMII_WIDTH    = 2;
    localparam int        BYTE_WIDTH    = 8;
    // Symbols per byte, less one, for each mode
    localparam logic [1:0] MII_LAST_SYM  = 2'h1;
    localparam logic [1:0] RMII_LAST_SYM = 2'h3;
    // Clock figures
    localparam int        CLK_HZ        = 20_000_000;
    localparam int        REF_SRC_HZ    = 100_000_000;
    localparam int        RMII_REF_HZ   = 50_000_000;
    // Activity LED stretch time and its cycle count
    localparam int        ACT_HOLD_MS   = 50;
    localparam int        ACT_HOLD_CYC  = ACT_HOLD_MS * (CLK_HZ / 1000);
    localparam int        ACT_CNT_W     = 24;
    // Values after reset
    localparam logic [3:0] TXD_RST      = 4'h0;
    localparam logic [7:0] BYTE_RST     = 8'h00;
    localparam logic [1:0] CNT_RST      = 2'h0;
    localparam logic      LED_DARK      = 1'b1;

    typedef enum logic {EPM_TX_IDLE, EPM_TX_SEND} epm_tx_state_e;
endpackage : epm_pkg

// ### epm_link_if.sv
// Carrier between the system-side port logic and the link-side port logic
interface epm_link_if;
    logic       rmii;
    logic       tx_req_tgl;
    logic [7:0] tx_byte;
    logic       tx_ack_tgl;
    logic       rx_tgl;
    logic [7:0] rx_byte;
    logic       rx_end_tgl;

    modport sys  (output rmii, tx_req_tgl, tx_byte, input tx_ack_tgl, rx_tgl, rx_byte, rx_end_tgl);
    modport link (input rmii, tx_req_tgl, tx_byte, output tx_ack_tgl, rx_tgl, rx_byte, rx_end_tgl);
endinterface : epm_link_if

// ### epm_sync.sv
// Two-flop level synchroniser
module epm_sync #(
    parameter int W = 1
) (
    // Destination clock
    input  wire logic         i_clk,
    // Level from the other domain
    input  wire logic [W-1:0] i_d,
    // Synchronised level
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clk) begin
        meta_q <= i_d;
        o_q    <= meta_q;
    end
endmodule : epm_sync

// ### epm_port.sv
// Link-side logic of one port: transmit serialiser and receive assembler
module epm_port (
    // Link clocks and reset request from the system domain
    input  wire logic       i_tx_clk,
    input  wire logic       i_rx_clk,
    input  wire logic       i_srst,
    // Carrier to the system side
    epm_link_if.link        lnk,
    // PHY pins
    input  wire logic       i_rx_valid,
    input  wire logic [3:0] i_rxd,
    output logic            o_tx_enable,
    output logic      [3:0] o_txd
);
    import epm_pkg::*;

    // Transmit clock domain
    logic       tx_rst_s;
    logic       tx_rmii_s;
    logic       tx_req_s;
    epm_sync #(.W(3)) u_tx_sync (
        .i_clk (i_tx_clk),
        .i_d   ({i_srst, lnk.rmii, lnk.tx_req_tgl}),
        .o_q   ({tx_rst_s, tx_rmii_s, tx_req_s})
    );

    function automatic logic [3:0] epm_sym(input logic [7:0] b, input logic rmii);
        epm_sym = rmii ? {2'b00, b[1:0]} : b[3:0];
    endfunction : epm_sym

    function automatic logic [1:0] epm_last(input logic rmii);
        epm_last = rmii ? RMII_LAST_SYM : MII_LAST_SYM;
    endfunction : epm_last

    epm_tx_state_e tx_st_q, tx_st_d;
    logic [7:0]    shift_q, shift_d;
    logic [1:0]    tcnt_q, tcnt_d;
    logic          seen_q, seen_d;
    logic          txen_q, txen_d;
    logic [3:0]    txd_q, txd_d;
    logic          load;

    always_comb begin
        tx_st_d = tx_st_q;
        shift_d = shift_q;
        tcnt_d  = tcnt_q;
        seen_d  = seen_q;
        txen_d  = txen_q;
        txd_d   = txd_q;
        // Next byte only at a byte boundary, so symbols never tear
        load    = (tx_req_s != seen_q) &&
                  (tx_st_q == EPM_TX_IDLE || tcnt_q == epm_last(tx_rmii_s));
        case (tx_st_q)
            EPM_TX_IDLE: begin
                txen_d = 1'b0;
                txd_d  = TXD_RST;
            end
            EPM_TX_SEND: begin
                // Last symbol has stood one clock; end unless a byte follows
                if (tcnt_q == epm_last(tx_rmii_s)) begin
                    tx_st_d = EPM_TX_IDLE;
                    txen_d  = 1'b0;
                    txd_d   = TXD_RST;
                end else begin
                    txd_d   = epm_sym(shift_q, tx_rmii_s);
                    shift_d = tx_rmii_s ? (shift_q >> RMII_WIDTH) : (shift_q >> MII_WIDTH);
                    tcnt_d  = tcnt_q + 2'h1;
                end
            end
            default: tx_st_d = EPM_TX_IDLE;
        endcase
        if (load) begin
            tx_st_d = EPM_TX_SEND;
            seen_d  = tx_req_s;
            txen_d  = 1'b1;
            txd_d   = epm_sym(lnk.tx_byte, tx_rmii_s);
            shift_d = tx_rmii_s ? (lnk.tx_byte >> RMII_WIDTH) : (lnk.tx_byte >> MII_WIDTH);
            tcnt_d  = CNT_RST;
        end
    end

    always_ff @(posedge i_tx_clk) begin
        if (tx_rst_s) begin
            tx_st_q <= EPM_TX_IDLE;
            shift_q <= BYTE_RST;
            tcnt_q  <= CNT_RST;
            seen_q  <= 1'b0;
            txen_q  <= 1'b0;
            txd_q   <= TXD_RST;
        end else begin
            tx_st_q <= tx_st_d;
            shift_q <= shift_d;
            tcnt_q  <= tcnt_d;
            seen_q  <= seen_d;
            txen_q  <= txen_d;
            txd_q   <= txd_d;
        end
    end

    assign lnk.tx_ack_tgl = seen_q;
    assign o_tx_enable    = txen_q;
    assign o_txd          = txd_q;

    // Receive clock domain
    logic       rx_rst_s;
    logic       rx_rmii_s;
    epm_sync #(.W(2)) u_rx_sync (
        .i_clk (i_rx_clk),
        .i_d   ({i_srst, lnk.rmii}),
        .o_q   ({rx_rst_s, rx_rmii_s})
    );

    logic       dv_q, dv_d;
    logic [3:0] rxd_q, rxd_d;
    logic       was_q, was_d;
    logic [7:0] acc_q, acc_d;
    logic [1:0] rcnt_q, rcnt_d;
    logic [7:0] rbyte_q, rbyte_d;
    logic       rtgl_q, rtgl_d;
    logic       etgl_q, etgl_d;

    always_comb begin
        dv_d    = i_rx_valid;
        rxd_d   = i_rxd;
        was_d   = dv_q;
        acc_d   = acc_q;
        rcnt_d  = rcnt_q;
        rbyte_d = rbyte_q;
        rtgl_d  = rtgl_q;
        etgl_d  = etgl_q;
        if (dv_q) begin
            acc_d  = rx_rmii_s ? {rxd_q[1:0], acc_q[7:2]} : {rxd_q, acc_q[7:4]};
            rcnt_d = rcnt_q + 2'h1;
            if (rcnt_q == epm_last(rx_rmii_s)) begin
                rbyte_d = acc_d;
                rtgl_d  = ~rtgl_q;
                rcnt_d  = CNT_RST;
            end
        end else begin
            rcnt_d = CNT_RST;
            // Partial byte at frame end is dropped
            if (was_q) begin
                etgl_d = ~etgl_q;
            end
        end
    end

    always_ff @(posedge i_rx_clk) begin
        if (rx_rst_s) begin
            dv_q    <= 1'b0;
            rxd_q   <= TXD_RST;
            was_q   <= 1'b0;
            acc_q   <= BYTE_RST;
            rcnt_q  <= CNT_RST;
            rbyte_q <= BYTE_RST;
            rtgl_q  <= 1'b0;
            etgl_q  <= 1'b0;
        end else begin
            dv_q    <= dv_d;
            rxd_q   <= rxd_d;
            was_q   <= was_d;
            acc_q   <= acc_d;
            rcnt_q  <= rcnt_d;
            rbyte_q <= rbyte_d;
            rtgl_q  <= rtgl_d;
            etgl_q  <= etgl_d;
        end
    end

    assign lnk.rx_tgl     = rtgl_q;
    assign lnk.rx_byte    = rbyte_q;
    assign lnk.rx_end_tgl = etgl_q;
endmodule : epm_port

// ### epm_top.sv
// Dual-port MII/RMII pin block: system-side logic, mode straps and RMII reference clock
// What this block does
// - Receive data taken only while valid high
// - RMII: valid input is CRS_DV
// - Link up while link status low
// - Activity output low lights LED
// - Carrier sense high means carrier present in MII; RMII takes carrier from CRS_DV
// - Collision input high means collision in MII, ignored in RMII
// - Transmit enable high exactly during frame
// - Transmit four bits MII, two RMII
// - Sample four bits MII, two RMII
// - MII timed to PHY transmit/receive clocks
// - RMII: one shared 50 MHz reference
module epm_top #(
    parameter int P_ACT_HOLD_CYC = epm_pkg::ACT_HOLD_CYC
) (
    // System clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // RMII reference source, twice the reference rate
    input  wire logic       i_ref_src_clk,
    output logic            o_rmii_ref_clk,
    // Port A PHY pins
    input  wire logic       i_port_a_tx_clock,
    input  wire logic       i_port_a_rx_clock,
    input  wire logic       i_port_a_rx_valid,
    input  wire logic [3:0] i_port_a_rxd,
    input  wire logic       i_port_a_carrier_sense,
    input  wire logic       i_port_a_collision,
    input  wire logic       i_port_a_link_up_n,
    input  wire logic       i_port_a_rmii_strap,
    output logic            o_port_a_tx_enable,
    output logic      [3:0] o_port_a_txd,
    output logic            o_port_a_activity_led_n,
    // Port B PHY pins
    input  wire logic       i_port_b_tx_clock,
    input  wire logic       i_port_b_rx_clock,
    input  wire logic       i_port_b_rx_valid,
    input  wire logic [3:0] i_port_b_rxd,
    input  wire logic       i_port_b_carrier_sense,
    input  wire logic       i_port_b_collision,
    input  wire logic       i_port_b_link_up_n,
    input  wire logic       i_port_b_rmii_strap,
    output logic            o_port_b_tx_enable,
    output logic      [3:0] o_port_b_txd,
    output logic            o_port_b_activity_led_n,
    // Port A user side
    input  wire logic [7:0] i_port_a_tx_data,
    input  wire logic       i_port_a_tx_valid,
    output logic            o_port_a_tx_ready,
    output logic      [7:0] o_port_a_rx_data,
    output logic            o_port_a_rx_valid,
    output logic            o_port_a_rx_end,
    output logic            o_port_a_link_up,
    output logic            o_port_a_carrier,
    output logic            o_port_a_collision,
    output logic            o_port_a_rmii,
    // Port B user side
    input  wire logic [7:0] i_port_b_tx_data,
    input  wire logic       i_port_b_tx_valid,
    output logic            o_port_b_tx_ready,
    output logic      [7:0] o_port_b_rx_data,
    output logic            o_port_b_rx_valid,
    output logic            o_port_b_rx_end,
    output logic            o_port_b_link_up,
    output logic            o_port_b_carrier,
    output logic            o_port_b_collision,
    output logic            o_port_b_rmii
);
    import epm_pkg::*;

    localparam logic [ACT_CNT_W-1:0] ACT_LOAD = ACT_CNT_W'(P_ACT_HOLD_CYC - 1);
    localparam logic [ACT_CNT_W-1:0] ACT_ZERO = '0;

    // RMII reference: divide-by-two keeps a 50 percent duty cycle
    logic ref_rst_s;
    logic ref_q, ref_d;
    epm_sync #(.W(1)) u_ref_sync (
        .i_clk (i_ref_src_clk),
        .i_d   (i_srst),
        .o_q   (ref_rst_s)
    );
    always_comb begin
        ref_d = ~ref_q;
    end
    always_ff @(posedge i_ref_src_clk) begin
        if (ref_rst_s) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= ref_d;
        end
    end
    assign o_rmii_ref_clk = ref_q;

    // Per-port pin arrays
    logic [NUM_PORTS-1:0]       strap_pin;
    logic [NUM_PORTS-1:0]       phy_tx_clk;
    logic [NUM_PORTS-1:0]       phy_rx_clk;
    logic [NUM_PORTS-1:0]       rxv_pin;
    logic [NUM_PORTS-1:0][3:0]  rxd_pin;
    logic [NUM_PORTS-1:0]       crs_pin;
    logic [NUM_PORTS-1:0]       col_pin;
    logic [NUM_PORTS-1:0]       lnk_n_pin;
    logic [NUM_PORTS-1:0][7:0]  txdata_in;
    logic [NUM_PORTS-1:0]       txvalid_in;
    logic [NUM_PORTS-1:0]       txen_out;
    logic [NUM_PORTS-1:0][3:0]  txd_out;

    assign strap_pin  = {i_port_b_rmii_strap, i_port_a_rmii_strap};
    assign phy_tx_clk = {i_port_b_tx_clock, i_port_a_tx_clock};
    assign phy_rx_clk = {i_port_b_rx_clock, i_port_a_rx_clock};
    assign rxv_pin    = {i_port_b_rx_valid, i_port_a_rx_valid};
    assign rxd_pin    = {i_port_b_rxd, i_port_a_rxd};
    assign crs_pin    = {i_port_b_carrier_sense, i_port_a_carrier_sense};
    assign col_pin    = {i_port_b_collision, i_port_a_collision};
    assign lnk_n_pin  = {i_port_b_link_up_n, i_port_a_link_up_n};
    assign txdata_in  = {i_port_b_tx_data, i_port_a_tx_data};
    assign txvalid_in = {i_port_b_tx_valid, i_port_a_tx_valid};

    // System-side registered outputs
    logic [NUM_PORTS-1:0]      mode_q;
    logic [NUM_PORTS-1:0]      ready_q;
    logic [NUM_PORTS-1:0][7:0] rxdata_q;
    logic [NUM_PORTS-1:0]      rxv_q;
    logic [NUM_PORTS-1:0]      rxe_q;
    logic [NUM_PORTS-1:0]      link_q;
    logic [NUM_PORTS-1:0]      crs_q;
    logic [NUM_PORTS-1:0]      col_q;
    logic [NUM_PORTS-1:0]      led_q;

    epm_link_if lnk[NUM_PORTS] ();

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        logic                 strap_s;
        logic [3:0]           stat_s;
        logic [2:0]           tgl_s;
        logic                 tx_clk;
        logic                 rx_clk;
        logic                 accept;
        logic                 mode_d;
        logic                 req_q, req_d;
        logic [7:0]           byte_q, byte_d;
        logic                 ready_d;
        logic                 rseen_q, rseen_d;
        logic                 eseen_q, eseen_d;
        logic                 rxv_d, rxe_d;
        logic [7:0]           rxdata_d;
        logic                 link_d, crs_d, col_d, led_d;
        logic [ACT_CNT_W-1:0] act_q, act_d;

        epm_sync #(.W(8)) u_sys_sync (
            .i_clk (i_clk),
            .i_d   ({strap_pin[p], lnk_n_pin[p], col_pin[p], crs_pin[p], rxv_pin[p],
                     lnk[p].tx_ack_tgl, lnk[p].rx_tgl, lnk[p].rx_end_tgl}),
            .o_q   ({strap_s, stat_s, tgl_s})
        );

        // Mode changes only under reset, so the clock switch never glitches mid-frame
        // PHY clocks in MII
        assign tx_clk = mode_q[p] ? ref_q : phy_tx_clk[p];
        assign rx_clk = mode_q[p] ? ref_q : phy_rx_clk[p];

        assign lnk[p].rmii       = mode_q[p];
        assign lnk[p].tx_req_tgl = req_q;
        assign lnk[p].tx_byte    = byte_q;

        epm_port u_port (
            .i_tx_clk    (tx_clk),
            .i_rx_clk    (rx_clk),
            .i_srst      (i_srst),
            .lnk         (lnk[p]),
            .i_rx_valid  (rxv_pin[p]),
            .i_rxd       (rxd_pin[p]),
            .o_tx_enable (txen_out[p]),
            .o_txd       (txd_out[p])
        );

        always_comb begin
            // strap followed while reset is asserted, then held after release
            mode_d   = i_srst ? strap_s : mode_q[p];
            accept   = txvalid_in[p] && ready_q[p];
            req_d    = req_q ^ accept;
            byte_d   = accept ? txdata_in[p] : byte_q;
            // Mailbox free once link side echoes the request
            ready_d  = (tgl_s[2] == req_d);
            rseen_d  = tgl_s[1];
            rxv_d    = (tgl_s[1] != rseen_q);
            rxdata_d = rxv_d ? lnk[p].rx_byte : rxdata_q[p];
            eseen_d  = tgl_s[0];
            rxe_d    = (tgl_s[0] != eseen_q);
            link_d   = ~stat_s[3];
            crs_d    = mode_q[p] ? stat_s[0] : stat_s[1];
            col_d    = ~mode_q[p] & stat_s[2];
            if (accept || rxv_d) begin
                act_d = ACT_LOAD;
            end else if (act_q != ACT_ZERO) begin
                act_d = act_q - 1'b1;
            end else begin
                act_d = act_q;
            end
            led_d    = ~(link_d && (act_d != ACT_ZERO));
        end

        always_ff @(posedge i_clk) begin
            if (i_srst) begin
                mode_q[p]   <= mode_d;
                req_q       <= 1'b0;
                byte_q      <= BYTE_RST;
                ready_q[p]  <= 1'b0;
                rseen_q     <= 1'b0;
                eseen_q     <= 1'b0;
                rxv_q[p]    <= 1'b0;
                rxe_q[p]    <= 1'b0;
                rxdata_q[p] <= BYTE_RST;
                link_q[p]   <= 1'b0;
                crs_q[p]    <= 1'b0;
                col_q[p]    <= 1'b0;
                led_q[p]    <= LED_DARK;
                act_q       <= ACT_ZERO;
            end else begin
                mode_q[p]   <= mode_d;
                req_q       <= req_d;
                byte_q      <= byte_d;
                ready_q[p]  <= ready_d;
                rseen_q     <= rseen_d;
                eseen_q     <= eseen_d;
                rxv_q[p]    <= rxv_d;
                rxe_q[p]    <= rxe_d;
                rxdata_q[p] <= rxdata_d;
                link_q[p]   <= link_d;
                crs_q[p]    <= crs_d;
                col_q[p]    <= col_d;
                led_q[p]    <= led_d;
                act_q       <= act_d;
            end
        end
    end

    assign o_port_a_tx_enable      = txen_out[0];
    assign o_port_a_txd            = txd_out[0];
    assign o_port_a_activity_led_n = led_q[0];
    assign o_port_b_tx_enable      = txen_out[1];
    assign o_port_b_txd            = txd_out[1];
    assign o_port_b_activity_led_n = led_q[1];
    assign o_port_a_tx_ready       = ready_q[0];
    assign o_port_a_rx_data        = rxdata_q[0];
    assign o_port_a_rx_valid       = rxv_q[0];
    assign o_port_a_rx_end         = rxe_q[0];
    assign o_port_a_link_up        = link_q[0];
    assign o_port_a_carrier        = crs_q[0];
    assign o_port_a_collision      = col_q[0];
    assign o_port_a_rmii           = mode_q[0];
    assign o_port_b_tx_ready       = ready_q[1];
    assign o_port_b_rx_data        = rxdata_q[1];
    assign o_port_b_rx_valid       = rxv_q[1];
    assign o_port_b_rx_end         = rxe_q[1];
    assign o_port_b_link_up        = link_q[1];
    assign o_port_b_carrier        = crs_q[1];
    assign o_port_b_collision      = col_q[1];
    assign o_port_b_rmii           = mode_q[1];
endmodule : epm_top

// ### epm_top_sva.sv
// Checker on the top ports of the dual-port pin block
module epm_top_sva #(
    parameter int P_ACT_HOLD_CYC = 16
) (
    input wire logic       i_clk,
    input wire logic       i_srst,
    input wire logic       i_port_a_tx_clock,
    input wire logic       o_port_a_tx_enable,
    input wire logic [3:0] o_port_a_txd,
    input wire logic [3:0] o_port_b_txd,
    input wire logic       o_port_b_rmii,
    input wire logic       i_port_a_link_up_n,
    input wire logic       o_port_a_link_up,
    input wire logic       i_port_a_carrier_sense,
    input wire logic       o_port_a_carrier,
    input wire logic       i_port_a_collision,
    input wire logic       o_port_a_collision,
    input wire logic       o_port_b_collision,
    input wire logic       o_port_a_activity_led_n,
    input wire logic       i_port_a_rx_valid,
    input wire logic       o_port_a_rx_valid
);
    logic [4:0] quiet_q, quiet_d;
    // Cycles since receive valid was last high, saturating
    always_comb begin
        quiet_d = quiet_q;
        if (i_port_a_rx_valid)
            quiet_d = 5'h00;
        else if (quiet_q != 5'h1f)
            quiet_d = quiet_q + 5'h01;
    end
    always_ff @(posedge i_clk) begin
        if (i_srst)
            quiet_q <= 5'h00;
        else
            quiet_q <= quiet_d;
    end
    AST_TXD_IDLE: assert property (@(posedge i_port_a_tx_clock) disable iff (i_srst)
        !o_port_a_tx_enable |-> o_port_a_txd == 4'h0) else $error("txd not zero while idle");
    AST_B_TXD_HI: assert property (@(posedge i_clk) disable iff (i_srst)
        o_port_b_rmii |-> o_port_b_txd[3:2] == 2'h0) else $error("upper txd used in reduced mode");
    AST_LINK: assert property (@(posedge i_clk) disable iff (i_srst)
        (!i_port_a_link_up_n) [*4] |-> o_port_a_link_up) else $error("link not up");
    AST_CARRIER: assert property (@(posedge i_clk) disable iff (i_srst)
        i_port_a_carrier_sense [*4] |-> o_port_a_carrier) else $error("carrier not seen");
    AST_COLL: assert property (@(posedge i_clk) disable iff (i_srst)
        i_port_a_collision [*4] |-> o_port_a_collision) else $error("collision not seen");
    AST_B_NO_COL: assert property (@(posedge i_clk) disable iff (i_srst)
        o_port_b_rmii |-> !o_port_b_collision) else $error("collision in reduced mode");
    AST_LED: assert property (@(posedge i_clk) disable iff (i_srst)
        (!o_port_a_link_up) [*3] |-> o_port_a_activity_led_n) else $error("led lit with link down");
    AST_RX_GATE: assert property (@(posedge i_clk) disable iff (i_srst)
        quiet_q >= 5'h14 |-> !o_port_a_rx_valid) else $error("byte without receive valid");
endmodule : epm_top_sva
bind epm_top epm_top_sva #(.P_ACT_HOLD_CYC(P_ACT_HOLD_CYC)) u_epm_top_sva (.*);

// ### epm_phy_model.sv
// Behavioural PHY for one port: MII clocks, transmit capture, receive driver
module epm_phy_model #(
    parameter realtime P_HALF = 80ns
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rmii,
    input  wire logic       i_tx_enable,
    input  wire logic [3:0] i_txd,
    output logic            o_tx_clock,
    output logic            o_rx_clock,
    output logic            o_rx_valid,
    output logic      [3:0] o_rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    wire        tck;
    wire        rck;
    logic [7:0] sr;
    logic [7:0] tx_byte;
    logic       hi_seen = 1'b0;
    logic       busy = 1'b0;
    int         nsym = 0;
    int         syms = 0;
    int         frames = 0;
    assign tck = i_rmii ? i_ref_clk : o_tx_clock;
    assign rck = i_rmii ? i_ref_clk : o_rx_clock;
    initial begin
        o_tx_clock = 1'b0;
        forever #(P_HALF) o_tx_clock = ~o_tx_clock;
    end
    initial begin
        o_rx_clock = 1'b0;
        o_rx_valid = 1'b0;
        o_rxd = 4'h0;
        #37;
        forever #(P_HALF) o_rx_clock = ~o_rx_clock;
    end
    always @(posedge tck) begin
        if (i_tx_enable === 1'b1) begin
            sr = i_rmii ? {i_txd[1:0], sr[7:2]} : {i_txd, sr[7:4]};
            if (i_rmii && i_txd[3:2] !== 2'h0)
                hi_seen = 1'b1;
            nsym = nsym + 1;
        end else if (nsym != 0) begin
            tx_byte = sr;
            syms = nsym;
            frames = frames + 1;
            nsym = 0;
        end
    end
    // Idle lines keep changing so stale data cannot pass as valid
    always @(posedge rck) begin
        if (!busy) begin
            #2;
            o_rxd = ~o_rxd;
        end
    end
    task automatic send_byte(input logic [7:0] b);
        int n;
        int w;
        w = i_rmii ? 2 : 4;
        busy = 1'b1;
        for (n = 0; n < 8; n += w) begin
            @(posedge rck);
            #2;
            o_rx_valid = 1'b1;
            o_rxd = i_rmii ? {~b[n +: 2], b[n +: 2]} : b[n +: 4];
        end
        @(posedge rck);
        #2;
        o_rx_valid = 1'b0;
        o_rxd = ~o_rxd;
        busy = 1'b0;
    endtask : send_byte
endmodule : epm_phy_model

// ### tb_epm_top.sv
// Bench for the dual-port pin block: port A in MII, port B in RMII
module tb_epm_top;
    timeunit 1ns;
    timeprecision 1ps;
    import epm_pkg::*;
    localparam int HOLD = 16;
    logic       clk;
    logic       srst;
    logic       rsrc;
    logic [1:0] lnk_n;
    logic [1:0] crs;
    logic [1:0] col;
    logic [1:0] strap;
    logic [1:0] txv;
    logic [7:0] txu [2];
    wire        ref_clk;
    wire  [1:0] tck, rck, pv, ten, led_n, rdy, rxv, rxe, lup, car, cls, rmii;
    wire  [3:0] prxd [2];
    wire  [3:0] txd [2];
    wire  [7:0] rxu [2];
    int         m_fr [2];
    int         m_sy [2];
    logic [7:0] m_by [2];
    logic       m_hi [2];
    logic [7:0] rx_got [2];
    int         rx_n [2] = '{0, 0};
    int         end_n [2] = '{0, 0};
    int         fails = 0;
    int         total_checks = 0;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rsrc = 1'b0;
        #3;
        forever #5 rsrc = ~rsrc;
    end
    for (genvar p = 0; p < 2; p++) begin : g_phy
        epm_phy_model u_epm_phy_model (.i_ref_clk(ref_clk), .i_rmii(strap[p]), .i_tx_enable(ten[p]),
            .i_txd(txd[p]), .o_tx_clock(tck[p]), .o_rx_clock(rck[p]), .o_rx_valid(pv[p]), .o_rxd(prxd[p]));
        assign m_fr[p] = u_epm_phy_model.frames;
        assign m_sy[p] = u_epm_phy_model.syms;
        assign m_by[p] = u_epm_phy_model.tx_byte;
        assign m_hi[p] = u_epm_phy_model.hi_seen;
    end
    epm_top #(.P_ACT_HOLD_CYC(HOLD)) u_epm_top (.i_clk(clk), .i_srst(srst), .i_ref_src_clk(rsrc),
        .o_rmii_ref_clk(ref_clk),
        .i_port_a_tx_clock(tck[0]), .i_port_a_rx_clock(rck[0]), .i_port_a_rx_valid(pv[0]), .i_port_a_rxd(prxd[0]),
        .i_port_a_carrier_sense(crs[0]), .i_port_a_collision(col[0]), .i_port_a_link_up_n(lnk_n[0]),
        .i_port_a_rmii_strap(strap[0]), .o_port_a_tx_enable(ten[0]), .o_port_a_txd(txd[0]),
        .o_port_a_activity_led_n(led_n[0]), .i_port_a_tx_data(txu[0]), .i_port_a_tx_valid(txv[0]),
        .o_port_a_tx_ready(rdy[0]), .o_port_a_rx_data(rxu[0]), .o_port_a_rx_valid(rxv[0]), .o_port_a_rx_end(rxe[0]),
        .o_port_a_link_up(lup[0]), .o_port_a_carrier(car[0]), .o_port_a_collision(cls[0]), .o_port_a_rmii(rmii[0]),
        .i_port_b_tx_clock(tck[1]), .i_port_b_rx_clock(rck[1]), .i_port_b_rx_valid(pv[1]), .i_port_b_rxd(prxd[1]),
        .i_port_b_carrier_sense(crs[1]), .i_port_b_collision(col[1]), .i_port_b_link_up_n(lnk_n[1]),
        .i_port_b_rmii_strap(strap[1]), .o_port_b_tx_enable(ten[1]), .o_port_b_txd(txd[1]),
        .o_port_b_activity_led_n(led_n[1]), .i_port_b_tx_data(txu[1]), .i_port_b_tx_valid(txv[1]),
        .o_port_b_tx_ready(rdy[1]), .o_port_b_rx_data(rxu[1]), .o_port_b_rx_valid(rxv[1]), .o_port_b_rx_end(rxe[1]),
        .o_port_b_link_up(lup[1]), .o_port_b_carrier(car[1]), .o_port_b_collision(cls[1]), .o_port_b_rmii(rmii[1]));
    always @(posedge clk) begin
        for (int p = 0; p < 2; p++) begin
            if (rxv[p] === 1'b1) begin
                rx_got[p] <= rxu[p];
                rx_n[p] <= rx_n[p] + 1;
            end
            if (rxe[p] === 1'b1)
                end_n[p] <= end_n[p] + 1;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic t_reset;
        chk(rmii, 2'h2);
        chk(ten, 2'h0);
        chk(lup, 2'h0);
        chk(led_n, 2'h3);
    endtask : t_reset
    task automatic t_ref;
        realtime t0;
        @(posedge ref_clk);
        t0 = $realtime;
        @(posedge ref_clk);
        chk(int'($realtime - t0), 20);
    endtask : t_ref
    task automatic t_status;
        lnk_n = 2'h0;
        crs = 2'h1;
        col = 2'h3;
        tick(6);
        chk(lup, 2'h3);
        chk(car[0], 1'b1);
        chk(cls, 2'h1);
        crs = 2'h0;
        col = 2'h0;
        tick(6);
        chk(car[0], 1'b0);
        chk(cls[0], 1'b0);
    endtask : t_status
    task automatic t_tx(input int p, input logic [7:0] b);
        int f0;
        int k;
        f0 = m_fr[p];
        txu[p] = b;
        txv[p] = 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rdy[p] !== 1'b1 && k < 40);
        #2;
        txv[p] = 1'b0;
        tick(3);
        if (p == 0)
            chk(led_n[0], 1'b0);
        for (k = 0; k < 200 && m_fr[p] == f0; k++)
            tick(1);
        chk(m_fr[p] - f0, 1);
        chk(m_by[p], b);
        chk(m_sy[p], p ? 4 : 2);
        chk(ten[p], 1'b0);
        chk(m_hi[1], 1'b0);
        tick(HOLD + 8);
        chk(led_n[p], 1'b1);
    endtask : t_tx
    task automatic t_rx(input int p, input logic [7:0] b);
        int n0;
        int e0;
        n0 = rx_n[p];
        e0 = end_n[p];
        tick(30);
        chk(rx_n[p] - n0, 0);
        if (p == 0)
            g_phy[0].u_epm_phy_model.send_byte(b);
        else
            g_phy[1].u_epm_phy_model.send_byte(b);
        tick(20);
        chk(rx_n[p] - n0, 1);
        chk(rx_got[p], b);
        chk(end_n[p] - e0, 1);
    endtask : t_rx
    initial begin
        #500000;
        fails++;
        summarize();
    end
    initial begin
        srst = 1'b1;
        lnk_n = 2'h3;
        crs = 2'h0;
        col = 2'h0;
        strap = 2'h2;
        txv = 2'h0;
        txu = '{8'h00, 8'h00};
        // Long enough for three edges of the slow link clocks
        tick(10);
        srst = 1'b0;
        tick(2);
        t_reset();
        t_ref();
        t_status();
        t_tx(0, 8'ha5);
        t_tx(1, 8'h3c);
        t_rx(0, 8'h5a);
        t_rx(1, 8'hc3);
        summarize();
    end
endmodule : tb_epm_top
